/* wch_pkg.sv */
// shared constants and carrier types for the wake and clock handshake block
package wch_pkg;
   localparam int WCH_SYNC_STAGES = 2;
   localparam logic [1:0] WCH_PAD_FUNC_HANDSHAKE = 2'h0;
   // sniff or hold wake timer, in low-power oscillator ticks
   localparam int WCH_TIMER_W = 16;
   localparam logic [15:0] WCH_TIMER_RST = 16'h0000;

   typedef enum logic [3:0] {
      WCH_ST_AWAKE = 4'h1,
      WCH_ST_SLEEP = 4'h2,
      WCH_ST_TIMED = 4'h4,
      WCH_ST_SHUT = 4'h8
   } wch_state_t;

   // software configuration bits
   typedef struct packed {
      logic hs_enable;
      logic uart_mode;
      logic dev_wake_act_high;
      logic host_wake_act_high;
      logic [1:0] pad_func_dev_wake;
      logic [1:0] pad_func_host_wake;
      logic [1:0] pad_func_clk_req;
   } wch_cfg_t;

   // radio power-down controls, one means powered down
   typedef struct packed {
      logic tx_pd;
      logic rx_pd;
      logic pll_pd;
      logic pa_pd;
   } wch_rf_pd_t;
endpackage

/* wch_sync.sv */
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module wch_sync
   import wch_pkg::*;
#(
   parameter int STAGES = WCH_SYNC_STAGES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic [STAGES-1:0] chain;
   } wch_sync_state_t;
   wch_sync_state_t st_r;
   wch_sync_state_t st_nxt;

   // refused at elaboration: one stage gives no metastability margin
   if (STAGES < 2) begin : g_bad_stages
      $error("wch_sync needs at least two stages");
   end

   // shift chain; first stage feeds only the second
   always_comb begin
      st_nxt = st_r;
      st_nxt.chain = {st_r.chain[STAGES-2:0], async_in};
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.chain[STAGES-1];
endmodule
`default_nettype wire

/* wch_top.sv */
// wake, clock request and radio power-down handshake logic
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - asserted device wake forces awake and blocks sleep
// - deasserted device wake allows sleep once internal criteria hold
// - device wake and host wake polarity each chosen by software
// - clock request rises when radio or wlan needs the reference clock
// - clock request is always active high, polarity settings ignored
// - handshake lines work only in uart mode and when enabled
// - power actions come from software writes or packet events
// - separate power-down outputs for tx, rx, pll and amplifier
// - pad function value zero selects the handshake on each pin
// - packet handling toggles radio power-downs within packets
// - sniff and hold run on slow oscillator, wake after a set period
module wch_top
   import wch_pkg::*;
#(
   parameter int TIMER_W = WCH_TIMER_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire wch_cfg_t cfg,
   input wire logic device_wake_in,
   input wire logic sleep_ok,
   input wire logic bt_clk_need,
   input wire logic wlan_clk_need,
   input wire logic host_attn,
   input wire logic sw_pd_wr,
   input wire wch_rf_pd_t sw_pd_val,
   input wire logic pkt_tx_on,
   input wire logic pkt_rx_on,
   input wire logic lp_mode_req,
   input wire logic [TIMER_W-1:0] lp_period,
   input wire logic lpo_tick,
   output logic host_wake_out,
   output logic host_wake_oe_n,
   output logic clk_req_out,
   output logic clk_req_oe_n,
   output logic lpo_select,
   output logic awake,
   output wch_state_t state,
   output wch_rf_pd_t rf_pd
);
   typedef struct packed {
      wch_state_t fsm;
      logic [TIMER_W-1:0] timer;
      wch_rf_pd_t sw_pd;
      wch_rf_pd_t rf_pd;
      logic host_wake;
      logic clk_req;
      logic lpo_sel;
      logic tick_d;
   } wch_top_state_t;

   wch_top_state_t st_r;
   wch_top_state_t st_nxt;
   logic dev_wake_sync;
   logic lpo_tick_sync;
   logic dev_wake_act;
   logic hs_live;
   logic tick_rise;

   // refused at elaboration: widths the countdown cannot serve
   if (TIMER_W < 2 || TIMER_W > 32) begin : g_bad_timer_w
      $error("wch_top timer width out of range");
   end

   // pins come from outside the clock domain
   wch_sync u_sync_wake (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(device_wake_in),
      .sync_out(dev_wake_sync)
   );
   wch_sync u_sync_tick (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(lpo_tick),
      .sync_out(lpo_tick_sync)
   );

   // pad mux must pick the handshake function on all three pins
   function automatic logic pads_ok(input wch_cfg_t c);
      pads_ok = (c.pad_func_dev_wake == WCH_PAD_FUNC_HANDSHAKE)
         && (c.pad_func_host_wake == WCH_PAD_FUNC_HANDSHAKE)
         && (c.pad_func_clk_req == WCH_PAD_FUNC_HANDSHAKE);
   endfunction

   // handshake gated by uart mode and enable
   assign hs_live = cfg.hs_enable && cfg.uart_mode && pads_ok(cfg);
   assign dev_wake_act = hs_live
      && (cfg.dev_wake_act_high ? dev_wake_sync : !dev_wake_sync);
   assign tick_rise = lpo_tick_sync && !st_r.tick_d;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick_d = lpo_tick_sync;
      // software power-down write, held until rewritten
      if (sw_pd_wr) begin
         st_nxt.sw_pd = sw_pd_val;
      end
      case (st_r.fsm)
         WCH_ST_AWAKE: begin
            if (!dev_wake_act && sleep_ok) begin
               if (lp_mode_req) begin
                  st_nxt.fsm = WCH_ST_TIMED;
                  st_nxt.timer = lp_period;
               end else begin
                  st_nxt.fsm = WCH_ST_SLEEP;
               end
            end
         end
         WCH_ST_SLEEP: begin
            if (dev_wake_act || !sleep_ok) begin
               st_nxt.fsm = WCH_ST_AWAKE;
            end
         end
         WCH_ST_TIMED: begin
            if (dev_wake_act || !sleep_ok) begin
               st_nxt.fsm = WCH_ST_AWAKE;
            end else if (tick_rise) begin
               if (st_r.timer <= TIMER_W'(1)) begin
                  st_nxt.fsm = WCH_ST_AWAKE;
               end else begin
                  st_nxt.timer = st_r.timer - TIMER_W'(1);
               end
            end
         end
         default: begin
            st_nxt.fsm = WCH_ST_AWAKE;
         end
      endcase
      st_nxt.lpo_sel = (st_nxt.fsm == WCH_ST_TIMED);
      // radio off while asleep; packets gate tx and rx inside a slot
      if (st_nxt.fsm != WCH_ST_AWAKE) begin
         st_nxt.rf_pd = '{tx_pd: 1'b1, rx_pd: 1'b1, pll_pd: 1'b1, pa_pd: 1'b1};
      end else begin
         st_nxt.rf_pd.tx_pd = st_nxt.sw_pd.tx_pd || !pkt_tx_on;
         st_nxt.rf_pd.rx_pd = st_nxt.sw_pd.rx_pd || !pkt_rx_on;
         st_nxt.rf_pd.pa_pd = st_nxt.sw_pd.pa_pd || !pkt_tx_on;
         st_nxt.rf_pd.pll_pd = st_nxt.sw_pd.pll_pd
            || !(pkt_tx_on || pkt_rx_on);
      end
      // host wake level follows polarity, idle level when not asserted
      st_nxt.host_wake = (hs_live && host_attn) == cfg.host_wake_act_high;
      // clock request fixed active high
      st_nxt.clk_req = hs_live && (bt_clk_need || wlan_clk_need);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r.fsm <= WCH_ST_AWAKE;
         st_r.timer <= '0;
         st_r.sw_pd <= '0;
         st_r.rf_pd <= '1;
         st_r.host_wake <= 1'b0;
         st_r.clk_req <= 1'b0;
         st_r.lpo_sel <= 1'b0;
         st_r.tick_d <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // pins driven only while the handshake is live
   assign host_wake_out = st_r.host_wake;
   assign host_wake_oe_n = !hs_live;
   assign clk_req_out = st_r.clk_req;
   assign clk_req_oe_n = !hs_live;
   assign lpo_select = st_r.lpo_sel;
   assign awake = (st_r.fsm == WCH_ST_AWAKE);
   assign state = st_r.fsm;
   assign rf_pd = st_r.rf_pd;

   a_wake_blocks_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dev_wake_act |=> st_r.fsm == WCH_ST_AWAKE)
      else $error("sleep entered while device wake asserted");
   a_sleep_needs_ok: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(st_r.fsm == WCH_ST_SLEEP) |-> $past(sleep_ok) && !$past(dev_wake_act))
      else $error("sleep without criteria");
   a_clk_req_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      hs_live && (bt_clk_need || wlan_clk_need) ##1 hs_live |-> clk_req_out)
      else $error("clock request missing");
   a_clk_req_pol: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(cfg.host_wake_act_high) && $stable(hs_live) && $stable(bt_clk_need)
      && $stable(wlan_clk_need) |=> $stable(clk_req_out))
      else $error("clock request moved with polarity");
   a_hs_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !cfg.uart_mode ##1 !cfg.uart_mode |-> !clk_req_out && host_wake_oe_n)
      else $error("handshake active outside uart mode");
   a_host_wake_pol: assert property (@(posedge clk_sys) disable iff (!rst_n)
      hs_live && host_attn |=> host_wake_out == $past(cfg.host_wake_act_high))
      else $error("host wake polarity wrong");
   a_sleep_pd_all: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_r.fsm != WCH_ST_AWAKE |-> rf_pd == 4'hf)
      else $error("radio powered while asleep");
   a_pkt_tx_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_nxt.fsm == WCH_ST_AWAKE && !st_nxt.sw_pd.tx_pd && !st_nxt.sw_pd.pa_pd && pkt_tx_on
      |=> !rf_pd.tx_pd && !rf_pd.pa_pd)
      else $error("tx path not powered during packet");
   a_sw_pd_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sw_pd_wr && sw_pd_val.rx_pd ##1 !sw_pd_wr |-> rf_pd.rx_pd)
      else $error("software power-down not applied");
   a_timed_lpo: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_r.fsm == WCH_ST_TIMED) == lpo_select)
      else $error("oscillator select mismatch");
endmodule
`default_nettype wire

/* wch_host_model.sv */
// host side model: drives device wake, watches host wake
`timescale 1ns/10ps
`default_nettype none
module wch_host_model (
   input wire logic need_dev,
   input wire logic dev_act_high,
   input wire logic host_act_high,
   input wire logic host_wake_out,
   output logic device_wake_in,
   output logic host_up
);
   // pin held at its active level for as long as the device is needed
   assign device_wake_in = need_dev ? dev_act_high : ~dev_act_high;
   // host stays up only while host wake shows its active level
   assign host_up = (host_wake_out == host_act_high);
endmodule
`default_nettype wire

/* tb_wch_top.sv */
// self-checking bench for the wake and clock handshake block
`timescale 1ns/10ps
`default_nettype none
module tb_wch_top;
   import wch_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   wch_cfg_t cfg;
   wch_rf_pd_t sw_pd_val, rf_pd;
   wch_state_t state;
   logic need_dev, sleep_ok, bt_clk_need, wlan_clk_need, host_attn, sw_pd_wr;
   logic pkt_tx_on, pkt_rx_on, lp_mode_req, lpo_tick, hit;
   logic [15:0] lp_period;
   logic device_wake_in, host_wake_out, host_wake_oe_n, clk_req_out, clk_req_oe_n;
   logic lpo_select, awake, host_up;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   // {hs_en, uart, host_hi, pad_nz, bt, wlan, attn, clk_req, host_wake, oe_n}
   logic [9:0] rows [8] = '{10'h3a4, 10'h394, 10'h38a, 10'h32c,
                            10'h302, 10'h1a9, 10'h2a9, 10'h3e9};

   wch_top u_wch_top (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
      .device_wake_in(device_wake_in), .sleep_ok(sleep_ok), .bt_clk_need(bt_clk_need),
      .wlan_clk_need(wlan_clk_need), .host_attn(host_attn), .sw_pd_wr(sw_pd_wr),
      .sw_pd_val(sw_pd_val), .pkt_tx_on(pkt_tx_on), .pkt_rx_on(pkt_rx_on),
      .lp_mode_req(lp_mode_req), .lp_period(lp_period), .lpo_tick(lpo_tick),
      .host_wake_out(host_wake_out), .host_wake_oe_n(host_wake_oe_n),
      .clk_req_out(clk_req_out), .clk_req_oe_n(clk_req_oe_n), .lpo_select(lpo_select),
      .awake(awake), .state(state), .rf_pd(rf_pd));

   wch_host_model u_wch_host_model (.need_dev(need_dev),
      .dev_act_high(cfg.dev_wake_act_high), .host_act_high(cfg.host_wake_act_high),
      .host_wake_out(host_wake_out), .device_wake_in(device_wake_in), .host_up(host_up));

   // free-running clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   // hang guard, far above the 68 cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         end_of_test;
      end
   end

   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one slow-oscillator period; notes whether awake showed at any edge
   task tick;
      hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         lpo_tick = (i < 4);
         step(1);
         hit = hit | (awake === 1'b1);
      end
   endtask

   task end_of_test;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      cfg = 10'h3c0;
      {need_dev, sleep_ok, bt_clk_need, wlan_clk_need, host_attn} = 5'h10;
      {sw_pd_wr, pkt_tx_on, pkt_rx_on, lp_mode_req, lpo_tick} = 5'h00;
      sw_pd_val = 4'h0;
      lp_period = 16'h0002;
      step(4);
      chk({clk_req_out, host_wake_out, lpo_select, rf_pd, awake}, 8'h1f);
      chk(state, WCH_ST_AWAKE);
      rst_n = 1'b1;
      // sleep_ok stays low so the device remains awake through the table
      foreach (rows[i]) begin
         cfg = {rows[i][9:8], 1'b1, rows[i][7], 1'b0, rows[i][6], 4'h0};
         {bt_clk_need, wlan_clk_need, host_attn} = rows[i][5:3];
         step(2);
         chk({clk_req_out, host_wake_out, host_wake_oe_n, clk_req_oe_n, host_up},
             {rows[i][2:0], rows[i][0], rows[i][3] & ~rows[i][0]});
      end
      // flip host wake polarity alone; clock request must not follow it
      cfg = 10'h3c0;
      {bt_clk_need, wlan_clk_need, host_attn} = 3'h4;
      step(2);
      cfg.host_wake_act_high = 1'b0;
      step(2);
      chk({clk_req_out, host_wake_out}, 2'h3);
      cfg = 10'h3c0;
      {bt_clk_need, wlan_clk_need, host_attn} = 3'h0;
      pkt_tx_on = 1'b1;
      step(2);
      chk(rf_pd, 4'h4);
      sw_pd_val = 4'h1;
      sw_pd_wr = 1'b1;
      step(1);
      sw_pd_wr = 1'b0;
      step(1);
      chk(rf_pd, 4'h5);
      pkt_rx_on = 1'b1;
      step(2);
      chk(rf_pd, 4'h1);
      // software holds rx down even while the packet wants it on
      sw_pd_val = 4'h4;
      sw_pd_wr = 1'b1;
      step(1);
      sw_pd_wr = 1'b0;
      step(1);
      chk(rf_pd, 4'h4);
      // sleep entry and exit with an active-low wake pin
      cfg.dev_wake_act_high = 1'b0;
      need_dev = 1'b0;
      step(6);
      chk(state, WCH_ST_AWAKE);
      sleep_ok = 1'b1;
      step(2);
      chk({state, awake, rf_pd}, {WCH_ST_SLEEP, 1'b0, 4'hf});
      need_dev = 1'b1;
      step(2);
      chk(state, WCH_ST_SLEEP);
      step(2);
      chk(state, WCH_ST_AWAKE);
      sleep_ok = 1'b0;
      cfg.dev_wake_act_high = 1'b1;
      step(4);
      // timed low-power stay of two slow ticks
      {lp_mode_req, sleep_ok, need_dev} = 3'h6;
      step(4);
      chk({state, lpo_select}, {WCH_ST_TIMED, 1'b1});
      tick;
      chk(hit, 1'b0);
      tick;
      chk(hit, 1'b1);
      end_of_test;
   end
endmodule
`default_nettype wire
